// ===== src/ppbl_pkg.sv
// constants, types and helpers shared by the lock command block
package ppbl_pkg;

  // instruction codes
  localparam logic [7:0] LOCK_CLEAR_CMD    = 8'ha6;
  localparam logic [7:0] FREEZE_SET_CMD    = 8'h91;
  localparam logic [7:0] LOCK_REG_READ_CMD = 8'ha7;

  // lock register layout and values after reset
  localparam int   LOCK_BIT_POS   = 0;
  localparam int   FREEZE_BIT_POS = 7;
  localparam logic LOCK_RESET     = 1'b1;
  localparam logic FREEZE_RESET   = 1'b0;

  // instruction length in sampling edges
  localparam logic [3:0] SPI_CMD_EDGES  = 4'h8;
  localparam logic [3:0] QUAD_CMD_EDGES = 4'h2;

  // internal operation time, rounded up to whole clock cycles
  localparam int         CLK_PERIOD_NS = 40;
  localparam int         OP_TIME_NS    = 1000;
  localparam int         OP_CYCLES     = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] OP_COUNT      = 6'(OP_CYCLES);

  // synchroniser width: sck, cs, four data lines
  localparam int PIN_SYNC_W = 6;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_CMD   = 5'h02,
    ST_ARMED = 5'h04,
    ST_READ  = 5'h08,
    ST_HOLD  = 5'h10
  } ppbl_state_t;

  typedef enum logic [1:0] {
    OP_NONE   = 2'h0,
    OP_CLEAR  = 2'h1,
    OP_FREEZE = 2'h2
  } ppbl_op_t;

  // shift one sample into the instruction byte, one or four lines wide
  function automatic logic [7:0] ppbl_shift(input logic [7:0] cur,
                                            input logic [3:0] io,
                                            input logic       quad);
    return quad ? {cur[3:0], io} : {cur[6:0], io[0]};
  endfunction : ppbl_shift

endpackage : ppbl_pkg

// ===== src/ppbl_sync.sv
// two-stage synchroniser for the serial pins
`timescale 1ns/10ps
module ppbl_sync
  import ppbl_pkg::*;
#(
  parameter int WIDTH = PIN_SYNC_W
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stage1Reg;
  logic [WIDTH-1:0] stage2Reg;

  // first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage1Reg <= '0;
      stage2Reg <= '0;
    end else begin
      stage1Reg <= pinIn;
      stage2Reg <= stage1Reg;
    end
  end

  assign pinSync = stage2Reg;

endmodule : ppbl_sync

// ===== src/ppbl_lock_cmd.sv
// lock-clear, freeze-set and lock-register read command handling
// What this block does
// - lock-clear only clears lock bit, persistent mode
// - lock-clear needs write enable latch set
// - lock-clear framed by cs rise after bit eight
// - lock-clear operation starts on cs rise
// - progress bit high during lock-clear operation
// - progress bit stays readable while busy
// - lock-clear completion clears write enable latch
// - freeze command only sets freeze bit seven
// - freeze needs write enable latch set
// - freeze framed by cs rise, starts there
// - progress bit high during freeze operation
// - freeze completion clears write enable latch
// - lock read repeats bytes, single-line only
`timescale 1ns/10ps
module ppbl_lock_cmd
  import ppbl_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       spiClk,
  input  wire logic       spiCsN,
  input  wire logic [3:0] spiIo,
  input  wire logic       quadMode,
  input  wire logic       persistentMode,
  input  wire logic       writeEnableLatch,
  input  wire logic       busyOther,
  output logic            soData,
  output logic            soOe,
  output logic            writeInProgress,
  output logic            welClear,
  output logic            persistentProtLock,
  output logic            freezeFlag
);

  logic [5:0]  pinSync;
  logic        sckQ;
  logic        csnQ;
  logic [3:0]  ioQ;
  logic        sckDlyReg;
  logic        csnDlyReg;
  ppbl_state_t stateReg;
  ppbl_state_t stateNext;
  logic [7:0]  shiftReg;
  logic [3:0]  edgeCntReg;
  ppbl_op_t    armOpReg;
  logic [2:0]  readIdxReg;
  logic        soReg;
  logic        soOeReg;
  ppbl_op_t    opKindReg;
  logic [5:0]  opCntReg;
  logic        wipReg;
  logic        welClrReg;
  logic        lockReg;
  logic        freezeReg;

  // pins cross into the core clock; cs crosses inverted so a flushed stage reads deselected
  ppbl_sync #(.WIDTH(PIN_SYNC_W)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pinIn    ({spiClk, ~spiCsN, spiIo}),
    .pinSync  (pinSync)
  );

  assign sckQ = pinSync[5];
  assign csnQ = ~pinSync[4];  // no false cs fall after reset
  assign ioQ  = pinSync[3:0];

  // edge detection on the synchronised pins
  logic sckRise;
  logic sckFall;
  logic csFall;
  logic csRise;
  assign sckRise = sckQ & ~sckDlyReg;
  assign sckFall = ~sckQ & sckDlyReg;
  assign csFall  = ~csnQ & csnDlyReg;
  assign csRise  = csnQ & ~csnDlyReg;

  // instruction decode
  logic [7:0] cmdNext;
  logic [3:0] cmdEdges;
  logic       cmdDone;
  logic       isClear;
  logic       isFreeze;
  logic       isRead;
  logic       idleOk;
  logic       acceptClear;
  logic       acceptFreeze;
  logic       acceptRead;
  assign cmdNext  = ppbl_shift(shiftReg, ioQ, quadMode);
  assign cmdEdges = quadMode ? QUAD_CMD_EDGES : SPI_CMD_EDGES;
  assign cmdDone  = (stateReg == ST_CMD) && sckRise && (4'(edgeCntReg + 4'h1) == cmdEdges);
  assign isClear  = (cmdNext == LOCK_CLEAR_CMD);
  assign isFreeze = (cmdNext == FREEZE_SET_CMD);
  assign isRead   = (cmdNext == LOCK_REG_READ_CMD);
  assign idleOk   = !wipReg && !busyOther;
  assign acceptClear  = isClear && writeEnableLatch && persistentMode && idleOk;
  assign acceptFreeze = isFreeze && writeEnableLatch && idleOk;
  assign acceptRead   = isRead && !quadMode && idleOk;

  // operation start and end
  logic       opStart;
  logic       opDone;
  logic [7:0] lockValue;
  assign opStart   = (stateReg == ST_ARMED) && csRise;
  assign opDone    = wipReg && (opCntReg == 6'h01);
  assign lockValue = {freezeReg, 6'h00, lockReg};

  // frame sequencing; cs high always ends the frame
  always_comb begin
    stateNext = stateReg;
    if (csnQ) begin
      stateNext = ST_IDLE;
    end else begin
      unique case (stateReg)
        ST_IDLE: begin
          if (csFall) stateNext = ST_CMD;
        end
        ST_CMD: begin
          if (cmdDone) begin
            if (acceptRead) stateNext = ST_READ;
            else if (acceptClear || acceptFreeze) stateNext = ST_ARMED;
            else stateNext = ST_HOLD;
          end
        end
        ST_ARMED: begin
          if (sckRise) stateNext = ST_HOLD;
        end
        ST_READ:  stateNext = ST_READ;
        ST_HOLD:  stateNext = ST_HOLD;
        default:  stateNext = ST_IDLE;
      endcase
    end
  end

  // frame registers and instruction shifter
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sckDlyReg  <= 1'b0;
      csnDlyReg  <= 1'b1;
      stateReg   <= ST_IDLE;
      shiftReg   <= 8'h00;
      edgeCntReg <= 4'h0;
      armOpReg   <= OP_NONE;
    end else begin
      sckDlyReg <= sckQ;
      csnDlyReg <= csnQ;
      stateReg  <= stateNext;
      if (csFall) begin
        edgeCntReg <= 4'h0;
      end else if ((stateReg == ST_CMD) && sckRise) begin
        shiftReg   <= cmdNext;
        edgeCntReg <= 4'(edgeCntReg + 4'h1);
      end
      if (cmdDone) armOpReg <= acceptClear ? OP_CLEAR : OP_FREEZE;
    end
  end

  // lock register readout, msb first, wraps every eight bits
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      soReg      <= 1'b0;
      soOeReg    <= 1'b0;
      readIdxReg <= 3'h0;
    end else begin
      soOeReg <= (stateNext == ST_READ);
      if (stateReg != ST_READ) begin
        readIdxReg <= 3'h0;
      end else if (sckFall) begin
        soReg      <= lockValue[~readIdxReg];
        readIdxReg <= 3'(readIdxReg + 3'h1);
      end
    end
  end

  // internal operation timer and bit updates
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wipReg    <= 1'b0;
      welClrReg <= 1'b0;
      opCntReg  <= 6'h00;
      opKindReg <= OP_NONE;
      lockReg   <= LOCK_RESET;
      freezeReg <= FREEZE_RESET;
    end else begin
      welClrReg <= opDone;
      if (opStart) begin
        wipReg    <= 1'b1;
        opCntReg  <= OP_COUNT;
        opKindReg <= armOpReg;
      end else if (opDone) begin
        wipReg   <= 1'b0;
        opCntReg <= 6'h00;
        if (opKindReg == OP_CLEAR) lockReg <= 1'b0;
        if (opKindReg == OP_FREEZE) freezeReg <= 1'b1;
      end else if (wipReg) begin
        opCntReg <= 6'(opCntReg - 6'h01);
      end
    end
  end

  // outputs straight from flops; progress bit visible at all times
  assign soData             = soReg;
  assign soOe               = soOeReg;
  assign writeInProgress    = wipReg;
  assign welClear           = welClrReg;
  assign persistentProtLock = lockReg;
  assign freezeFlag         = freezeReg;

  // checks on the command behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_lock_never_sets;
    !$rose(lockReg);
  endproperty
  a_lock_never_sets: assert property (p_lock_never_sets)
    else $error("lock bit was set by this block");

  property p_clear_needs_mode;
    (cmdDone && isClear && !persistentMode) |=> (stateReg == ST_HOLD);
  endproperty
  a_clear_needs_mode: assert property (p_clear_needs_mode)
    else $error("lock clear armed outside persistent mode");

  property p_clear_needs_wel;
    (cmdDone && isClear && !writeEnableLatch) |=> (stateReg != ST_ARMED);
  endproperty
  a_clear_needs_wel: assert property (p_clear_needs_wel)
    else $error("lock clear armed without write enable");

  property p_freeze_needs_wel;
    (cmdDone && isFreeze && !writeEnableLatch) |=> (stateReg != ST_ARMED);
  endproperty
  a_freeze_needs_wel: assert property (p_freeze_needs_wel)
    else $error("freeze armed without write enable");

  property p_extra_edge_discards;
    (stateReg == ST_ARMED && sckRise && !csnQ) |=> (stateReg == ST_HOLD) ##1 !wipReg;
  endproperty
  a_extra_edge_discards: assert property (p_extra_edge_discards)
    else $error("overlong write frame not discarded");

  property p_start_on_cs_rise;
    opStart |=> wipReg && (opKindReg == $past(armOpReg));
  endproperty
  a_start_on_cs_rise: assert property (p_start_on_cs_rise)
    else $error("operation did not start at cs rise");

  property p_wip_span;
    $rose(wipReg) |-> ##25 $fell(wipReg);
  endproperty
  a_wip_span: assert property (p_wip_span)
    else $error("progress bit span wrong");

  property p_wel_clear_on_done;
    $fell(wipReg) |-> welClrReg ##1 !welClrReg;
  endproperty
  a_wel_clear_on_done: assert property (p_wel_clear_on_done)
    else $error("write enable clear pulse missing");

  property p_freeze_only_sets;
    !$fell(freezeReg) && (!$rose(freezeReg) || ($past(opKindReg) == OP_FREEZE));
  endproperty
  a_freeze_only_sets: assert property (p_freeze_only_sets)
    else $error("freeze bit changed wrongly");

  property p_read_spi_only;
    (cmdDone && quadMode) |=> (stateReg != ST_READ);
  endproperty
  a_read_spi_only: assert property (p_read_spi_only)
    else $error("lock read accepted in four-line mode");

  property p_quad_two_edges;
    (stateReg == ST_CMD && quadMode && sckRise && edgeCntReg == 4'h1) |=> (stateReg != ST_CMD);
  endproperty
  a_quad_two_edges: assert property (p_quad_two_edges)
    else $error("four-line instruction not done after two edges");

  c_clear_done: cover property (opDone && opKindReg == OP_CLEAR);
  c_freeze_done: cover property (opDone && opKindReg == OP_FREEZE);
  c_read_wrap: cover property (stateReg == ST_READ && sckFall && readIdxReg == 3'h7);
  c_quad_armed: cover property (cmdDone && quadMode && acceptFreeze);

endmodule : ppbl_lock_cmd

// ===== verif/ppbl_host_model.sv
// host model driving the serial pins of the lock command block
`timescale 1ns/10ps
module ppbl_host_model (
  input  wire logic        core_clk,
  input  wire logic        soData,
  input  wire logic        soOe,
  output logic             spiClk,
  output logic             spiCsN,
  output logic [3:0]       spiIo,
  output logic [15:0]      rdBits,
  output logic             oeSeen
);
  // one serial clock phase, slow enough for the pin synchroniser
  task automatic half();
    repeat (6) @(negedge core_clk);
  endtask : half

  // one frame: nEdge instruction edges, then extra read edges
  task automatic frame(input logic [7:0] code, input logic quad, input int nEdge,
                       input int extra);
    logic [7:0] sr;
    int         i;
    sr = code;
    oeSeen = 1'b0;
    @(negedge core_clk);
    spiCsN = 1'b0;
    for (i = 0; i < nEdge + extra; i++) begin
      if (i < nEdge) begin
        spiIo = quad ? sr[7:4] : {~sr[7], ~sr[7], ~sr[7], sr[7]};
        sr = quad ? {sr[3:0], 4'h0} : {sr[6:0], 1'b0};
      end else begin
        spiIo = ~spiIo; // idle lines keep toggling
      end
      half();
      if (i >= nEdge) begin
        rdBits = {rdBits[14:0], soData};
        oeSeen = oeSeen | soOe;
      end
      spiClk = 1'b1;
      half();
      spiClk = 1'b0;
    end
    half();
    spiCsN = 1'b1;
    half();
  endtask : frame

  // idle pins at time zero
  initial begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiIo = 4'h0;
    rdBits = 16'h0000;
    oeSeen = 1'b0;
  end
endmodule : ppbl_host_model

// ===== verif/ppb_lock_freeze_commands_tb.sv
// self-checking bench for the lock-clear, freeze-set and lock read commands
`timescale 1ns/10ps
module ppb_lock_freeze_commands_tb;
  import ppbl_pkg::*;
  logic        core_clk, rst_n, quadMode, persistentMode, writeEnableLatch, busyOther;
  logic        spiClk, spiCsN, soData, soOe, writeInProgress, welClear, oeSeen;
  logic        persistentProtLock, freezeFlag, lockExp, frzExp;
  logic [3:0]  spiIo;
  logic [15:0] rdBits;
  logic [7:0]  codes [3];
  int          mismatches, numChecks, seed, x, n, wipCyc, welPulses, wipEarly;

  ppbl_lock_cmd dut_u (.core_clk(core_clk), .rst_n(rst_n), .spiClk(spiClk),
    .spiCsN(spiCsN), .spiIo(spiIo), .quadMode(quadMode), .persistentMode(persistentMode),
    .writeEnableLatch(writeEnableLatch), .busyOther(busyOther), .soData(soData),
    .soOe(soOe), .writeInProgress(writeInProgress), .welClear(welClear),
    .persistentProtLock(persistentProtLock), .freezeFlag(freezeFlag));
  ppbl_host_model host_u (.core_clk(core_clk), .soData(soData), .soOe(soOe),
    .spiClk(spiClk), .spiCsN(spiCsN), .spiIo(spiIo), .rdBits(rdBits), .oeSeen(oeSeen));

  // clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // outside write enable latch, cleared on the completion pulse
  always @(negedge core_clk) if (welClear === 1'b1) writeEnableLatch = 1'b0;

  // progress monitor
  always @(negedge core_clk) begin
    if (writeInProgress === 1'b1) wipCyc++;
    if (welClear === 1'b1) welPulses++;
    if (writeInProgress === 1'b1 && spiCsN === 1'b0) wipEarly++;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    if (mismatches == 0 && numChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  function automatic logic accepts(input logic [7:0] c, input logic q, input int ne,
                                   input int ex);
    return (c == LOCK_CLEAR_CMD && persistentMode || c == FREEZE_SET_CMD) && ex == 0
      && ne == 32'(q ? QUAD_CMD_EDGES : SPI_CMD_EDGES) && writeEnableLatch && !busyOther;
  endfunction : accepts

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    lockExp = LOCK_RESET;
    frzExp = FREEZE_RESET;
    check("reset", 16'({soOe, writeInProgress, welClear, freezeFlag, persistentProtLock}),
      16'({3'h0, FREEZE_RESET, LOCK_RESET}));
  endtask : do_reset

  // one write command and its whole operation
  task automatic wr(input logic [7:0] c, input logic q, input int ne, input int ex);
    logic acc, expWel;
    acc = accepts(c, q, ne, ex);
    expWel = writeEnableLatch & ~acc;
    if (acc && c == LOCK_CLEAR_CMD) lockExp = 1'b0;
    if (acc && c == FREEZE_SET_CMD) frzExp = 1'b1;
    quadMode = q;
    wipCyc = 0;
    welPulses = 0;
    wipEarly = 0;
    host_u.frame(c, q, ne, ex);
    repeat (40) @(negedge core_clk);
    check("wip_cycles", 16'(wipCyc), acc ? 16'(OP_CYCLES) : 16'h0000);
    check("wip_early", 16'(wipEarly), 16'h0000);
    check("wel_pulse", 16'(welPulses), 16'(acc));
    check("wel", 16'(writeEnableLatch), 16'(expWel));
    check("flags", 16'({freezeFlag, persistentProtLock}), 16'({frzExp, lockExp}));
  endtask : wr

  task automatic rd(input logic q);
    quadMode = q;
    host_u.frame(LOCK_REG_READ_CMD, q, q ? 2 : 8, 16);
    check("read_oe", 16'(oeSeen), 16'(!q));
    if (!q) check("read_data", rdBits, {2{frzExp, 6'h00, lockExp}});
  endtask : rd

  // main sequence: corner cases, then random frames
  initial begin
    seed = 32'h7e3b;
    codes = '{LOCK_CLEAR_CMD, FREEZE_SET_CMD, 8'h5c};
    {rst_n, quadMode, persistentMode, writeEnableLatch, busyOther} = 5'h04;
    {mismatches, numChecks} = '0;
    do_reset();
    rd(1'b0);
    rd(1'b1);
    wr(LOCK_CLEAR_CMD, 1'b0, 8, 0);
    writeEnableLatch = 1'b1;
    persistentMode = 1'b0;
    wr(LOCK_CLEAR_CMD, 1'b0, 8, 0);
    persistentMode = 1'b1;
    wr(LOCK_CLEAR_CMD, 1'b0, 7, 0);
    wr(LOCK_CLEAR_CMD, 1'b0, 8, 1);
    busyOther = 1'b1;
    wr(LOCK_CLEAR_CMD, 1'b0, 8, 0);
    busyOther = 1'b0;
    wr(LOCK_CLEAR_CMD, 1'b0, 8, 0);
    wr(FREEZE_SET_CMD, 1'b1, 2, 0);
    writeEnableLatch = 1'b1;
    wr(FREEZE_SET_CMD, 1'b1, 1, 0);
    wr(FREEZE_SET_CMD, 1'b1, 2, 0);
    rd(1'b0);
    do_reset();
    writeEnableLatch = 1'b1;
    wr(LOCK_CLEAR_CMD, 1'b1, 2, 0);
    writeEnableLatch = 1'b1;
    wr(FREEZE_SET_CMD, 1'b0, 8, 0);
    rd(1'b0);
    repeat (12) begin
      x = $random(seed);
      {writeEnableLatch, persistentMode, busyOther} = {x[0], x[1], x[2] & x[3]};
      n = (x[6] ? 2 : 8) - 32'(x[9] & x[10]);
      wr(codes[x[5:4] % 3], x[6], n, 32'(x[7] & x[8]));
    end
    end_sim();
  end

  // watchdog
  initial begin
    repeat (30000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end
endmodule : ppb_lock_freeze_commands_tb
